// ==== hdl/sfpfe_pkg.sv ====
// Shared constants, lane modes and state encoding for the serial flash pin front end.
package sfpfe_pkg;

    // ----------------------------------------------------------------
    // Data sizes
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int TX_DEPTH = 32;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [7:0] TX_FILL = 8'hff;

    // ----------------------------------------------------------------
    // Opcodes seen by the front end
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_QUAD_ENTER = 8'h35;
    localparam logic [7:0] OP_QUAD_EXIT = 8'hf5;

    // ----------------------------------------------------------------
    // Lane widths and output enables
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LANE_SINGLE = 2'h0,
        LANE_DUAL = 2'h1,
        LANE_QUAD = 2'h2
    } sfpfe_lane_type;

    localparam logic [3:0] OE_NONE = 4'h0;
    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_DUAL = 4'h3;
    localparam logic [3:0] OE_QUAD = 4'hf;

    typedef enum logic [1:0] {
        ST_POWERUP = 2'h0,
        ST_STANDBY = 2'h1,
        ST_ACTIVE = 2'h3,
        ST_PAUSE = 2'h2
    } sfpfe_state_type;

    // Bits moved per serial clock edge for a lane mode.
    function automatic logic [3:0] lane_step(input sfpfe_lane_type m);
        case (m)
            LANE_DUAL: lane_step = 4'h2;
            LANE_QUAD: lane_step = 4'h4;
            default: lane_step = 4'h1;
        endcase
    endfunction : lane_step

    // Output enables for a lane mode.
    function automatic logic [3:0] lane_oe(input sfpfe_lane_type m);
        case (m)
            LANE_DUAL: lane_oe = OE_DUAL;
            LANE_QUAD: lane_oe = OE_QUAD;
            default: lane_oe = OE_SINGLE;
        endcase
    endfunction : lane_oe

endpackage : sfpfe_pkg

// ==== hdl/sfpfe_stream_if.sv ====
// Valid and ready stream carrier between the front end modules.
`timescale 1ns/1ps
interface sfpfe_stream_if #(parameter int W = 8) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sfpfe_stream_if

// ==== hdl/sfpfe_fifo.sv ====
// Synchronous FIFO with width and depth parameters and valid and ready on both sides.
`timescale 1ns/1ps
module sfpfe_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Fill side and drain side
    sfpfe_stream_if.snk wr,
    sfpfe_stream_if.src rd
);
    import sfpfe_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic full, empty, push, pop;

    // ----------------------------------------------------------------
    // Pointers
    // ----------------------------------------------------------------
    always_comb begin
        empty = (wr_q == rd_q);
        full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
        push = wr.valid && !full;
        pop = rd.ready && !empty;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= wr.data;
        end
    end

    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rd_q[AW-1:0]];

endmodule : sfpfe_fifo

// ==== hdl/sfpfe_top.sv ====
// Pin front end of a serial flash: select, standby, pause, lane sampling and driving.
// Notes on behaviour
// - Select high: deselected, all outputs floated, standby state.
// - Select low: leave standby, accept instructions and move data.
// - After power-up nothing is taken until select falls from high.
// - No data bits are taken while select is high.
// - Single-lane input is sampled on the rising serial clock edge.
// - Single-lane output changes on the falling serial clock edge.
// - Dual and quad lanes sample on rising edge, drive on falling edge.
// - Quad transfers use write-protect as lane two, pause as lane three.
// - Quad enable low outside four-lane command mode: lane three is pause input; otherwise data lane only.
// - Pause low while selected floats outputs and freezes the sequence.
// - Opcode 35h enters four-lane command mode, F5h or reset leaves it.
// - Works with hosts in clock modes 0 and 3.
`timescale 1ns/1ps
module sfpfe_top #(
    parameter int TX_DEPTH = sfpfe_pkg::TX_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Serial pins
    input wire logic sel_n,
    input wire logic sck,
    input wire logic [3:0] data_lane_in,
    output logic [3:0] data_lane_out,
    output logic [3:0] data_lane_oe,
    // Configuration
    input wire logic quad_lane_enable,
    input wire logic mode_reset,
    input wire sfpfe_pkg::sfpfe_lane_type xfer_lanes,
    input wire logic xfer_drive,
    // Received bytes
    output logic [sfpfe_pkg::DATA_W-1:0] rx_data,
    output logic rx_valid,
    output logic rx_first,
    // Bytes to send
    input wire logic [sfpfe_pkg::DATA_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // Status
    output logic standby,
    output logic paused,
    output logic write_protect_active,
    output logic four_lane_command_mode
);
    import sfpfe_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [5:0] sync1_q, sync2_q, prev_q;
    logic sel_s, sck_s, sck_rise, sck_fall, sel_rise;
    logic [3:0] lane_s;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Select starts as not yet seen high, so power-up waits for a real high level.
            // Write-protect and pause lanes start at their released high level.
            sync1_q <= 6'h30;
            sync2_q <= 6'h30;
            prev_q <= 6'h30;
        end else begin
            sync1_q <= {data_lane_in, sck, sel_n};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    always_comb begin
        sel_s = sync2_q[0];
        sck_s = sync2_q[1];
        lane_s = sync2_q[5:2];
        // Edges come from the sampled level, so either idle clock level works.
        sck_rise = sck_s && !prev_q[1];
        sck_fall = !sck_s && prev_q[1];
        sel_rise = sel_s && !prev_q[0];
    end

    // ----------------------------------------------------------------
    // Transmit FIFO
    // ----------------------------------------------------------------
    sfpfe_stream_if #(.W(DATA_W)) tx_wr ();
    sfpfe_stream_if #(.W(DATA_W)) tx_rd ();

    assign tx_wr.valid = tx_valid;
    assign tx_wr.data = tx_data;
    assign tx_ready = tx_wr.ready;

    sfpfe_fifo #(.W(DATA_W), .DEPTH(TX_DEPTH)) u_tx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr(tx_wr),
        .rd(tx_rd)
    );

    // ----------------------------------------------------------------
    // Frame state and shifting
    // ----------------------------------------------------------------
    sfpfe_state_type state_q, state_d;
    sfpfe_lane_type in_mode, out_mode;
    logic [7:0] in_sh_q, in_sh_d, out_sh_q, out_sh_d, word;
    logic [3:0] in_cnt_q, in_cnt_d, out_cnt_q, out_cnt_d, sum;
    logic first_done_q, first_done_d, quad_q, quad_d;
    logic pause_req, driving, sample;
    logic [7:0] rx_data_q, rx_data_d;
    logic rx_valid_q, rx_valid_d, rx_first_q, rx_first_d;
    logic [3:0] out_q, out_d, oe_q, oe_d;
    logic wp_q, wp_d;

    always_comb begin
        state_d = state_q;
        in_sh_d = in_sh_q;
        in_cnt_d = in_cnt_q;
        out_sh_d = out_sh_q;
        out_cnt_d = out_cnt_q;
        first_done_d = first_done_q;
        quad_d = quad_q;
        rx_data_d = rx_data_q;
        rx_valid_d = 1'b0;
        rx_first_d = rx_first_q;
        out_d = out_q;
        tx_rd.ready = 1'b0;
        word = out_sh_q;
        sum = CNT_ZERO;
        // Pause exists only while lane three is not a data lane.
        pause_req = !lane_s[3] && !quad_lane_enable && !quad_q;
        in_mode = first_done_q ? xfer_lanes : (quad_q ? LANE_QUAD : LANE_SINGLE);
        out_mode = xfer_lanes;
        driving = first_done_q && xfer_drive;
        sample = 1'b0;
        case (state_q)
            // Wait for select to be seen high before anything counts.
            ST_POWERUP: begin
                if (sel_s) begin
                    state_d = ST_STANDBY;
                end
            end
            // Falling select leaves standby.
            ST_STANDBY: begin
                if (!sel_s) begin
                    state_d = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (sel_s) begin
                    state_d = ST_STANDBY;
                end else if (pause_req) begin
                    state_d = ST_PAUSE;
                end else begin
                    sample = sck_rise && !driving;
                end
            end
            // The sequence is held, not reset, while paused.
            default: begin
                if (sel_s) begin
                    state_d = ST_STANDBY;
                end else if (!pause_req) begin
                    state_d = ST_ACTIVE;
                end
            end
        endcase
        // Rising edge samples lanes; quad uses lanes two and three too.
        if (sample) begin
            case (in_mode)
                LANE_DUAL: in_sh_d = {in_sh_q[5:0], lane_s[1:0]};
                LANE_QUAD: in_sh_d = {in_sh_q[3:0], lane_s[3:0]};
                default: in_sh_d = {in_sh_q[6:0], lane_s[0]};
            endcase
            sum = in_cnt_q + lane_step(in_mode);
            in_cnt_d = sum;
            if (sum == BYTE_BITS) begin
                in_cnt_d = CNT_ZERO;
                rx_data_d = in_sh_d;
                rx_valid_d = 1'b1;
                rx_first_d = !first_done_q;
                first_done_d = 1'b1;
                if (!first_done_q && in_sh_d == OP_QUAD_ENTER) begin
                    quad_d = 1'b1;
                end else if (!first_done_q && in_sh_d == OP_QUAD_EXIT) begin
                    quad_d = 1'b0;
                end
            end
        end
        // Falling edge moves the next bits out of the transmit word.
        if (state_q == ST_ACTIVE && state_d == ST_ACTIVE && driving && sck_fall) begin
            if (out_cnt_q == CNT_ZERO) begin
                word = tx_rd.valid ? tx_rd.data : TX_FILL;
                tx_rd.ready = 1'b1;
            end
            case (out_mode)
                LANE_DUAL: out_d = {2'h0, word[7:6]};
                LANE_QUAD: out_d = word[7:4];
                default: out_d = {2'h0, word[7], 1'b0};
            endcase
            out_sh_d = 8'(word << lane_step(out_mode));
            out_cnt_d = out_cnt_q + lane_step(out_mode);
            if (out_cnt_d == BYTE_BITS) begin
                out_cnt_d = CNT_ZERO;
            end
        end
        // Deselect drops any partial byte and ends the frame.
        if (state_d == ST_STANDBY || state_d == ST_POWERUP) begin
            in_cnt_d = CNT_ZERO;
            out_cnt_d = CNT_ZERO;
            first_done_d = 1'b0;
        end
        if (mode_reset) begin
            quad_d = 1'b0;
        end
        // Outputs float unless selected, not paused and driving.
        oe_d = (state_d == ST_ACTIVE && driving) ? lane_oe(out_mode) : OE_NONE;
        wp_d = !lane_s[2] && !quad_lane_enable && !quad_q;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_POWERUP;
            in_sh_q <= 8'h00;
            in_cnt_q <= CNT_ZERO;
            out_sh_q <= 8'h00;
            out_cnt_q <= CNT_ZERO;
            first_done_q <= 1'b0;
            quad_q <= 1'b0;
            rx_data_q <= 8'h00;
            rx_valid_q <= 1'b0;
            rx_first_q <= 1'b0;
            out_q <= 4'h0;
            oe_q <= OE_NONE;
            wp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            in_sh_q <= in_sh_d;
            in_cnt_q <= in_cnt_d;
            out_sh_q <= out_sh_d;
            out_cnt_q <= out_cnt_d;
            first_done_q <= first_done_d;
            quad_q <= quad_d;
            rx_data_q <= rx_data_d;
            rx_valid_q <= rx_valid_d;
            rx_first_q <= rx_first_d;
            out_q <= out_d;
            oe_q <= oe_d;
            wp_q <= wp_d;
        end
    end

    assign data_lane_out = out_q;
    assign data_lane_oe = oe_q;
    assign rx_data = rx_data_q;
    assign rx_valid = rx_valid_q;
    assign rx_first = rx_first_q;
    assign standby = (state_q == ST_STANDBY) || (state_q == ST_POWERUP);
    assign paused = (state_q == ST_PAUSE);
    assign write_protect_active = wp_q;
    assign four_lane_command_mode = quad_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_desel_float;
        @(posedge clk) disable iff (sys_rst)
        (sel_s && state_q != ST_POWERUP) |=> (state_q == ST_STANDBY && data_lane_oe == OE_NONE);
    endproperty
    a_desel_float: assert property (p_desel_float) else $error("select high did not float outputs");

    property p_select_wakes;
        @(posedge clk) disable iff (sys_rst)
        (state_q == ST_STANDBY && !sel_s) |=> (state_q == ST_ACTIVE && !standby);
    endproperty
    a_select_wakes: assert property (p_select_wakes) else $error("select low did not leave standby");

    property p_powerup_quiet;
        @(posedge clk) disable iff (sys_rst)
        (state_q == ST_POWERUP) |=> !rx_valid;
    endproperty
    a_powerup_quiet: assert property (p_powerup_quiet) else $error("byte taken before first select");

    property p_no_rx_deselected;
        @(posedge clk) disable iff (sys_rst)
        sel_s |=> !rx_valid;
    endproperty
    a_no_rx_deselected: assert property (p_no_rx_deselected) else $error("byte taken while deselected");

    property p_rx_on_rise;
        @(posedge clk) disable iff (sys_rst)
        $rose(rx_valid) |-> $past(sck_rise);
    endproperty
    a_rx_on_rise: assert property (p_rx_on_rise) else $error("byte completed off a rising edge");

    property p_out_on_fall;
        @(posedge clk) disable iff (sys_rst)
        $changed(data_lane_out) |-> $past(sck_fall) && $past(state_q) == ST_ACTIVE;
    endproperty
    a_out_on_fall: assert property (p_out_on_fall) else $error("output changed off a falling edge");

    property p_quad_no_pause;
        @(posedge clk) disable iff (sys_rst)
        (quad_lane_enable && state_q == ST_ACTIVE) |=> state_q != ST_PAUSE;
    endproperty
    a_quad_no_pause: assert property (p_quad_no_pause) else $error("pause taken with quad enable set");

    property p_pause_hold;
        @(posedge clk) disable iff (sys_rst)
        (state_q == ST_PAUSE) ##1 (state_q == ST_PAUSE) |-> $stable(in_cnt_q) && data_lane_oe == OE_NONE;
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("sequence moved or output driven in pause");

    property p_quad_enter;
        @(posedge clk) disable iff (sys_rst)
        $rose(four_lane_command_mode) |-> rx_valid && rx_first && rx_data == OP_QUAD_ENTER;
    endproperty
    a_quad_enter: assert property (p_quad_enter) else $error("four-lane mode entered without opcode");

    property p_partial_drop;
        @(posedge clk) disable iff (sys_rst)
        sel_rise |=> (in_cnt_q == CNT_ZERO) [*2];
    endproperty
    a_partial_drop: assert property (p_partial_drop) else $error("partial byte kept over deselect");

endmodule : sfpfe_top

// ==== test/sfpfe_host_model.sv ====
// Behavioural SPI host that drives select, serial clock and the four data lanes.
`timescale 1ns/1ps
module sfpfe_host_model (
    // Clock for the idle lane pattern
    input wire logic clk,
    // Pins
    output logic sel_n,
    output logic sck,
    output logic [3:0] lane,
    input wire logic [3:0] dut_out,
    input wire logic [3:0] dut_oe
);
    logic [3:0] host_oe = 4'hc;
    logic [3:0] host_val = 4'hc;
    logic [3:0] junk = 4'h5;
    logic cpol = 1'b0;

    // Lanes that nobody drives toggle every cycle, so stale data never passes for valid data.
    always @(posedge clk) junk <= ~junk;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lane[i] = dut_oe[i] ? dut_out[i] : (host_oe[i] ? host_val[i] : junk[i]);
        end
    end

    // Sets the idle clock level of the chosen mode, then lowers select.
    task automatic start(input logic pol);
        cpol = pol;
        sck = pol;
        #48;
        sel_n = 1'b0;
        #24;
    endtask : start

    task automatic stop();
        sck = cpol;
        #24;
        sel_n = 1'b1;
        #48;
        host_oe = 4'hc;
        // Released write-protect and pause lanes return to their pull-up level.
        host_val = 4'hc;
    endtask : stop

    // Writes change on the fall; reads are taken at the end of the high phase, before the next fall.
    task automatic xfer(input logic [7:0] wr, input int w, input int ncyc, input bit rd, output logic [7:0] got);
        logic [3:0] mask;
        mask = (w == 4) ? 4'hf : ((w == 2) ? 4'h3 : (rd ? 4'h2 : 4'h1));
        host_oe = rd ? (~mask & 4'hd) : (mask | 4'hc);
        got = 8'h00;
        for (int c = 0; c < ncyc; c++) begin
            sck = 1'b0;
            if (!rd) host_val = (host_val & ~mask) | (4'(wr >> (8 - w * (c + 1))) & mask);
            #24;
            sck = 1'b1;
            #24;
            if (rd) got = (got << w) | 8'((w == 1) ? {3'h0, lane[1]} : (lane & mask));
        end
    endtask : xfer
endmodule : sfpfe_host_model

// ==== test/serial_flash_pin_front_end_tb.sv ====
// Self-checking bench for the serial flash pin front end driven by a behavioural host.
`timescale 1ns/1ps
module serial_flash_pin_front_end_tb;
    import sfpfe_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sel_n, sck, rx_valid, rx_first, tx_ready, standby, paused, wpa, fcm;
    logic quad_lane_enable, mode_reset, xfer_drive, tx_valid;
    sfpfe_lane_type xfer_lanes;
    logic [3:0] lane, dout, doe;
    logic [7:0] tx_data;
    logic [7:0] rx_data, got, b;
    logic [3:0] oe_exp [3] = '{4'h2, 4'h3, 4'hf};
    logic [8:0] rx_q [$];
    logic [7:0] tx_q [$];
    int bad_count = 0;
    int n_checks = 0;

    always #2.5 clk = ~clk;

    sfpfe_host_model i_host (.clk(clk), .sel_n(sel_n), .sck(sck), .lane(lane), .dut_out(dout), .dut_oe(doe));
    sfpfe_top i_dut (.clk(clk), .sys_rst(sys_rst), .sel_n(sel_n), .sck(sck), .data_lane_in(lane),
        .data_lane_out(dout), .data_lane_oe(doe), .quad_lane_enable(quad_lane_enable), .mode_reset(mode_reset),
        .xfer_lanes(xfer_lanes), .xfer_drive(xfer_drive), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_first(rx_first), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .standby(standby),
        .paused(paused), .write_protect_active(wpa), .four_lane_command_mode(fcm));

    task automatic check(input logic [8:0] g, input logic [8:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // Random first byte that is neither mode opcode.
    function automatic logic [7:0] rnd();
        return 8'($urandom) | 8'h82;
    endfunction : rnd

    task automatic wr(input logic [7:0] v, input int w, input bit first);
        rx_q.push_back({first, v});
        i_host.xfer(v, w, 8 / w, 1'b0, got);
    endtask : wr

    task automatic rd(input int w);
        logic [7:0] e;
        e = (tx_q.size() != 0) ? tx_q.pop_front() : TX_FILL;
        i_host.xfer(8'h00, w, 8 / w, 1'b1, got);
        check({1'b0, got}, {1'b0, e});
    endtask : rd

    task automatic frame_end();
        i_host.stop();
        for (int i = 0; i < 40 && rx_q.size() != 0; i++) @(posedge clk);
        if (rx_q.size() != 0) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, rx_q.size(), 0);
            results();
        end
    endtask : frame_end

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // Every received byte is matched against the oldest note.
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            if (rx_q.size() == 0) begin
                bad_count++;
                $display("unexpected at %0t: got %h expected %h", $time, {rx_first, rx_data}, 9'h000);
            end else begin
                check({rx_first, rx_data}, rx_q.pop_front());
            end
        end
    end

    initial begin
        void'($urandom(69));
        quad_lane_enable <= 1'b0;
        mode_reset <= 1'b0;
        xfer_drive <= 1'b0;
        tx_valid <= 1'b0;
        xfer_lanes <= LANE_SINGLE;
        tx_data <= 8'h00;
        i_host.sel_n = 1'b0;
        i_host.sck = 1'b0;
        settle(3);
        sys_rst <= 1'b0;
        settle(4);
        check({8'h0, standby}, 9'h001);
        i_host.xfer(8'($urandom), 1, 8, 1'b0, got);
        frame_end();
        i_host.xfer(8'($urandom), 1, 8, 1'b0, got);
        settle(8);
        check({4'h0, standby, doe}, 9'h010);
        for (int p = 0; p < 2; p++) begin
            i_host.start(p[0]);
            check({8'h0, standby}, 9'h000);
            for (int k = 0; k < 3; k++) wr(k == 0 ? rnd() : 8'($urandom), 1, k == 0);
            frame_end();
            check({4'h0, standby, doe}, 9'h010);
        end
        i_host.start(1'b0);
        i_host.xfer(OP_QUAD_ENTER, 1, 5, 1'b0, got);
        frame_end();
        check({8'h0, fcm}, 9'h000);
        i_host.start(1'b0);
        wr(OP_QUAD_ENTER, 1, 1'b1);
        frame_end();
        check({8'h0, fcm}, 9'h001);
        quad_lane_enable <= 1'b1;
        i_host.start(1'b1);
        wr(rnd(), 4, 1'b1);
        frame_end();
        i_host.start(1'b0);
        wr(OP_QUAD_EXIT, 4, 1'b1);
        frame_end();
        check({8'h0, fcm}, 9'h000);
        i_host.start(1'b0);
        wr(OP_QUAD_ENTER, 1, 1'b1);
        frame_end();
        @(posedge clk) mode_reset <= 1'b1;
        @(posedge clk) mode_reset <= 1'b0;
        settle(2);
        check({8'h0, fcm}, 9'h000);
        quad_lane_enable <= 1'b0;
        b = rnd();
        i_host.start(1'b0);
        rx_q.push_back({1'b1, b});
        i_host.xfer(b, 1, 4, 1'b0, got);
        i_host.host_val[3] = 1'b0;
        settle(8);
        check({4'h0, paused, doe}, 9'h010);
        i_host.xfer(8'($urandom), 1, 2, 1'b0, got);
        i_host.host_val[3] = 1'b1;
        settle(8);
        i_host.xfer(b << 4, 1, 4, 1'b0, got);
        frame_end();
        i_host.host_val[2] = 1'b0;
        settle(4);
        check({8'h0, wpa}, 9'h001);
        quad_lane_enable <= 1'b1;
        i_host.host_val[3] = 1'b0;
        settle(4);
        check({7'h0, wpa, paused}, 9'h000);
        i_host.start(1'b0);
        wr(rnd(), 1, 1'b1);
        frame_end();
        i_host.host_val = 4'hc;
        for (int i = 0; i < 40; i++) begin
            settle(1);
            if (tx_ready !== 1'b1) break;
            b = 8'($urandom);
            tx_q.push_back(b);
            tx_data <= b;
            tx_valid <= 1'b1;
            @(posedge clk) tx_valid <= 1'b0;
        end
        check(9'(tx_q.size()), 9'h020);
        xfer_drive <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            xfer_lanes <= sfpfe_lane_type'(m);
            i_host.start(1'b1);
            wr(rnd(), 1, 1'b1);
            for (int k = 0; k < (m == 2 ? 25 : 4); k++) begin
                rd(1 << m);
                if (k == 0) check({5'h0, doe}, {5'h0, oe_exp[m]});
                #($urandom_range(0, 150));
            end
            frame_end();
        end
        results();
    end
endmodule : serial_flash_pin_front_end_tb
